// *** osem_pkg.sv ***
// shared constants for the output stage enable and output mux register bank
package osem_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] ADDR_MUX    = 8'h3D;  // output_mux_select
  localparam logic [7:0] ADDR_PHONES = 8'h5A;  // headphone stage enables
  localparam logic [7:0] ADDR_LINE   = 8'h5E;  // line_output_stage_enables
  localparam logic [7:0] ADDR_STAT_A = 8'h70;  // sequence status, phones right and line left
  localparam logic [7:0] ADDR_STAT_B = 8'h71;  // sequence status, line right and bad address

  // ==========================================================================
  // decoder select positions
  localparam int SEL_MUX    = 0;
  localparam int SEL_PHONES = 1;
  localparam int SEL_LINE   = 2;
  localparam int SEL_STAT_A = 3;
  localparam int SEL_STAT_B = 4;
  localparam int SEL_W      = 5;
  typedef logic [SEL_W-1:0] osem_sel_t;

  // ==========================================================================
  // headphone enable register fields
  localparam int PH_R_INPUT  = 0;
  localparam int PH_R_MIDDLE = 1;
  localparam int PH_R_OUTPUT = 2;
  localparam int PH_R_SHORT  = 3;
  localparam int PH_L_SHORT  = 7;

  // line output register fields
  localparam int LN_R_INPUT  = 0;
  localparam int LN_R_MIDDLE = 1;
  localparam int LN_R_OUTPUT = 2;
  localparam int LN_R_SHORT  = 3;
  localparam int LN_L_INPUT  = 4;
  localparam int LN_L_MIDDLE = 5;
  localparam int LN_L_OUTPUT = 6;
  localparam int LN_L_SHORT  = 7;

  // output mux select fields
  localparam int MX_LINE_R   = 0;
  localparam int MX_LINE_L   = 1;
  localparam int MX_PHONES_R = 2;
  localparam int MX_PHONES_L = 3;

  // ==========================================================================
  // values after reset
  localparam logic [7:0] RST_PHONES = 8'h00;
  localparam logic [7:0] RST_LINE   = 8'h00;
  localparam logic [3:0] RST_MUX    = 4'h0;
  localparam logic [3:0] RST_STAT   = 4'h0;

  // ==========================================================================
  // sequence watch channels and status nibble layout
  localparam int CH_NUM      = 3;
  localparam int CH_PHONES_R = 0;
  localparam int CH_LINE_L   = 1;
  localparam int CH_LINE_R   = 2;
  localparam int ST_SETTLED  = 0;  // input stage on for the full settle time
  localparam int ST_EARLY    = 1;  // middle stage enabled too soon
  localparam int ST_NO_MID   = 2;  // output stage enabled before middle stage
  localparam int ST_NO_OUT   = 3;  // short released before output stage
  localparam int ST_BAD_ADDR = 7;  // in status B
  localparam logic [3:0] ST_CLR_MASK = 4'hE;  // settled bit is live, not clearable

  // ==========================================================================
  // settle time between input stage and middle stage
  localparam int SETTLE_NS     = 20000;
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [7:0] SETTLE_CYC =
    8'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// *** osem_bus_if.sv ***
// register port carrier between the bank and its address decoder
`timescale 1ns/1ps
interface osem_bus_if;
  import osem_pkg::*;
  logic [7:0] addr;
  logic       wr;
  logic       rd;
  osem_sel_t  sel;
  logic       unmapped;

  modport decoder (input addr, input wr, input rd, output sel, output unmapped);
  modport core    (output addr, output wr, output rd, input sel, input unmapped);
endinterface

// *** osem_reg_decode.sv ***
// address decoder for the register bank
`timescale 1ns/1ps
module osem_reg_decode (
  osem_bus_if.decoder bus
);
  import osem_pkg::*;

  // ==========================================================================
  // one-hot select; an access that hits nothing is flagged as unmapped
  always_comb begin
    bus.sel = '0;
    case (bus.addr)
      ADDR_MUX:    bus.sel[SEL_MUX]    = 1'b1;
      ADDR_PHONES: bus.sel[SEL_PHONES] = 1'b1;
      ADDR_LINE:   bus.sel[SEL_LINE]   = 1'b1;
      ADDR_STAT_A: bus.sel[SEL_STAT_A] = 1'b1;
      ADDR_STAT_B: bus.sel[SEL_STAT_B] = 1'b1;
      default:     bus.sel = '0;
    endcase
    bus.unmapped = (bus.wr | bus.rd) & ~(|bus.sel);
  end

endmodule

// *** osem_seq_watch.sv ***
// enable sequence watch for one output channel
`timescale 1ns/1ps
module osem_seq_watch (
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       clk_en_i,
  input  wire logic       input_on_i,
  input  wire logic       middle_on_i,
  input  wire logic       output_on_i,
  input  wire logic       short_release_i,
  input  wire logic [3:0] clear_i,
  output logic      [3:0] status_o
);
  import osem_pkg::*;

  logic [7:0] settle_cnt;
  logic       settled;
  logic       middle_q;
  logic       output_q;
  logic       short_q;
  logic       early_evt;
  logic       no_mid_evt;
  logic       no_out_evt;

  // ==========================================================================
  // settle timer: restarts whenever the input stage is off, saturates
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      settle_cnt <= 8'h00;
    end else if (clk_en_i) begin
      if (!input_on_i) begin
        settle_cnt <= 8'h00;
      end else if (settle_cnt != SETTLE_CYC) begin
        settle_cnt <= settle_cnt + 8'h01;
      end
    end
  end

  assign settled = (settle_cnt == SETTLE_CYC);

  // ==========================================================================
  // previous stage levels for rising edge detection
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      middle_q <= 1'b0;
      output_q <= 1'b0;
      short_q  <= 1'b0;
    end else if (clk_en_i) begin
      middle_q <= middle_on_i;
      output_q <= output_on_i;
      short_q  <= short_release_i;
    end
  end

  // out of order steps are reported, never blocked: the analogue path obeys software
  assign early_evt  = middle_on_i & ~middle_q & ~settled;
  assign no_mid_evt = output_on_i & ~output_q & ~middle_on_i;
  assign no_out_evt = short_release_i & ~short_q & ~output_on_i;

  // ==========================================================================
  // live settled bit and sticky event flags; a new event in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_o <= RST_STAT;
    end else if (clk_en_i) begin
      status_o[ST_SETTLED] <= settled;
      status_o[ST_EARLY]   <= early_evt  | (status_o[ST_EARLY]  & ~clear_i[ST_EARLY]);
      status_o[ST_NO_MID]  <= no_mid_evt | (status_o[ST_NO_MID] & ~clear_i[ST_NO_MID]);
      status_o[ST_NO_OUT]  <= no_out_evt | (status_o[ST_NO_OUT] & ~clear_i[ST_NO_OUT]);
    end
  end

endmodule

// *** osem_regs.sv ***
// output stage enable and output mux register bank, top level
//
// Contract
// - headphone register bit 0 turns on right headphone input stage; set first.
// - middle stage enables: phones right bit 1, line left 5, right 1.
// - line register bit 7 releases left line short; set last.
// - line register bit 6 enables left line output stage.
// - line register bit 4 enables left line input stage; set first.
// - line register bit 3 releases right line short; set last.
// - line register bit 2 enables right line output stage.
// - line register bit 0 enables right line input stage; set first.
// - all mux selects reset to zero, routing converter to each amplifier.
// - mux bit 3 picks left converter or left bypass for left phones.
// - mux bit 2 picks right converter or right bypass for right phones.
// - mux bit 1 picks left converter or left bypass for left line.
// - mux bit 0 picks right converter or right bypass for right line.
// - headphone register bit 7 releases left headphone short; set last.
// - headphone register bit 3 releases right headphone short.
// - headphone register bit 2 enables right headphone output stage.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module osem_regs (
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       clk_en_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output logic            right_phones_input_stage_on_o,
  output logic            right_phones_middle_stage_on_o,
  output logic            right_phones_output_stage_on_o,
  output logic            right_phones_short_release_o,
  output logic            left_phones_short_release_o,
  output logic            left_line_input_stage_on_o,
  output logic            left_line_middle_stage_on_o,
  output logic            left_line_output_stage_on_o,
  output logic            left_line_short_release_o,
  output logic            right_line_input_stage_on_o,
  output logic            right_line_middle_stage_on_o,
  output logic            right_line_output_stage_on_o,
  output logic            right_line_short_release_o,
  output logic            left_phones_bypass_select_o,
  output logic            right_phones_bypass_select_o,
  output logic            left_line_bypass_select_o,
  output logic            right_line_bypass_select_o
);
  import osem_pkg::*;

  osem_bus_if bus ();

  logic [7:0] phones_stage_enables;
  logic [7:0] line_output_stage_enables;
  logic [3:0] output_mux_select;
  logic       bad_addr;
  logic       wr_phones;
  logic       wr_line;
  logic       wr_mux;
  logic       wr_stat_a;
  logic       wr_stat_b;
  logic [3:0] ch_input [CH_NUM];
  logic [3:0] ch_clear [CH_NUM];
  logic [3:0] ch_status [CH_NUM];
  logic       ch_in_on [CH_NUM];
  logic       ch_mid_on [CH_NUM];
  logic       ch_out_on [CH_NUM];
  logic       ch_short [CH_NUM];
  logic [7:0] next_rdata;

  // ==========================================================================
  // register port and decode
  assign bus.addr = reg_addr_i;
  assign bus.wr   = reg_wr_i;
  assign bus.rd   = reg_rd_i;

  osem_reg_decode u_decode (
    .bus (bus.decoder)
  );

  assign wr_phones = reg_wr_i & bus.sel[SEL_PHONES];
  assign wr_line   = reg_wr_i & bus.sel[SEL_LINE];
  assign wr_mux    = reg_wr_i & bus.sel[SEL_MUX];
  assign wr_stat_a = reg_wr_i & bus.sel[SEL_STAT_A];
  assign wr_stat_b = reg_wr_i & bus.sel[SEL_STAT_B];

  // ==========================================================================
  // headphone stage enables; left stage bits 6:4 are kept as plain storage
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phones_stage_enables <= RST_PHONES;
    end else if (clk_en_i && wr_phones) begin
      phones_stage_enables <= reg_wdata_i;
    end
  end

  // ==========================================================================
  // line output stage enables, both channels in one register
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      line_output_stage_enables <= RST_LINE;
    end else if (clk_en_i && wr_line) begin
      line_output_stage_enables <= reg_wdata_i;
    end
  end

  // ==========================================================================
  // output mux selects; zero after reset routes the converters through
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      output_mux_select <= RST_MUX;
    end else if (clk_en_i && wr_mux) begin
      output_mux_select <= reg_wdata_i[3:0];
    end
  end

  // ==========================================================================
  // analogue controls straight from the stored bits, no extra delay
  assign right_phones_input_stage_on_o  = phones_stage_enables[PH_R_INPUT];
  assign right_phones_middle_stage_on_o = phones_stage_enables[PH_R_MIDDLE];
  assign right_phones_output_stage_on_o = phones_stage_enables[PH_R_OUTPUT];
  assign right_phones_short_release_o   = phones_stage_enables[PH_R_SHORT];
  assign left_phones_short_release_o    = phones_stage_enables[PH_L_SHORT];

  assign left_line_input_stage_on_o   = line_output_stage_enables[LN_L_INPUT];
  assign left_line_middle_stage_on_o  = line_output_stage_enables[LN_L_MIDDLE];
  assign left_line_output_stage_on_o  = line_output_stage_enables[LN_L_OUTPUT];
  assign left_line_short_release_o    = line_output_stage_enables[LN_L_SHORT];
  assign right_line_input_stage_on_o  = line_output_stage_enables[LN_R_INPUT];
  assign right_line_middle_stage_on_o = line_output_stage_enables[LN_R_MIDDLE];
  assign right_line_output_stage_on_o = line_output_stage_enables[LN_R_OUTPUT];
  assign right_line_short_release_o   = line_output_stage_enables[LN_R_SHORT];

  assign left_phones_bypass_select_o  = output_mux_select[MX_PHONES_L];
  assign right_phones_bypass_select_o = output_mux_select[MX_PHONES_R];
  assign left_line_bypass_select_o    = output_mux_select[MX_LINE_L];
  assign right_line_bypass_select_o   = output_mux_select[MX_LINE_R];

  // ==========================================================================
  // per channel stage bits gathered for the sequence watches
  assign ch_input[CH_PHONES_R] = {phones_stage_enables[PH_R_SHORT],
                                  phones_stage_enables[PH_R_OUTPUT],
                                  phones_stage_enables[PH_R_MIDDLE],
                                  phones_stage_enables[PH_R_INPUT]};
  assign ch_input[CH_LINE_L]   = line_output_stage_enables[LN_L_SHORT:LN_L_INPUT];
  assign ch_input[CH_LINE_R]   = line_output_stage_enables[LN_R_SHORT:LN_R_INPUT];

  // write one to clear; the live settled bit is masked out
  assign ch_clear[CH_PHONES_R] = wr_stat_a ? (reg_wdata_i[3:0] & ST_CLR_MASK) : 4'h0;
  assign ch_clear[CH_LINE_L]   = wr_stat_a ? (reg_wdata_i[7:4] & ST_CLR_MASK) : 4'h0;
  assign ch_clear[CH_LINE_R]   = wr_stat_b ? (reg_wdata_i[3:0] & ST_CLR_MASK) : 4'h0;

  // ==========================================================================
  // one watch per channel; it only reports, since the pop order is software's job
  for (genvar ch = 0; ch < CH_NUM; ch++) begin : g_watch
    assign ch_in_on[ch]  = ch_input[ch][0];
    assign ch_mid_on[ch] = ch_input[ch][1];
    assign ch_out_on[ch] = ch_input[ch][2];
    assign ch_short[ch]  = ch_input[ch][3];

    osem_seq_watch u_watch (
      .sys_clk_i       (sys_clk_i),
      .sys_rst_i       (sys_rst_i),
      .clk_en_i        (clk_en_i),
      .input_on_i      (ch_in_on[ch]),
      .middle_on_i     (ch_mid_on[ch]),
      .output_on_i     (ch_out_on[ch]),
      .short_release_i (ch_short[ch]),
      .clear_i         (ch_clear[ch]),
      .status_o        (ch_status[ch])
    );
  end

  // ==========================================================================
  // sticky flag for an access to no register; set wins over clear
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bad_addr <= 1'b0;
    end else if (clk_en_i) begin
      bad_addr <= bus.unmapped | (bad_addr & ~(wr_stat_b & reg_wdata_i[ST_BAD_ADDR]));
    end
  end

  // ==========================================================================
  // read mux; unused upper bits and unmapped reads give zero
  always_comb begin
    next_rdata = 8'h00;
    case (1'b1)
      bus.sel[SEL_MUX]:    next_rdata = {4'h0, output_mux_select};
      bus.sel[SEL_PHONES]: next_rdata = phones_stage_enables;
      bus.sel[SEL_LINE]:   next_rdata = line_output_stage_enables;
      bus.sel[SEL_STAT_A]: next_rdata = {ch_status[CH_LINE_L], ch_status[CH_PHONES_R]};
      bus.sel[SEL_STAT_B]: next_rdata = {bad_addr, 3'h0, ch_status[CH_LINE_R]};
      default:             next_rdata = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      reg_rdata_o <= reg_rd_i ? next_rdata : 8'h00;
    end
  end

endmodule

// *** osem_regs_monitor.sv ***
// concurrent port checks for the output stage enable and mux register bank
`timescale 1ns/1ps
module osem_regs_monitor
  import osem_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       clk_en_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       right_phones_input_stage_on_o,
  input wire logic       right_phones_middle_stage_on_o,
  input wire logic       right_phones_output_stage_on_o,
  input wire logic       right_phones_short_release_o,
  input wire logic       left_phones_short_release_o,
  input wire logic       left_line_input_stage_on_o,
  input wire logic       left_line_middle_stage_on_o,
  input wire logic       left_line_output_stage_on_o,
  input wire logic       left_line_short_release_o,
  input wire logic       right_line_input_stage_on_o,
  input wire logic       right_line_middle_stage_on_o,
  input wire logic       right_line_output_stage_on_o,
  input wire logic       right_line_short_release_o,
  input wire logic       left_phones_bypass_select_o,
  input wire logic       right_phones_bypass_select_o,
  input wire logic       left_line_bypass_select_o,
  input wire logic       right_line_bypass_select_o
);
  // ==========================================================================
  // output groups in register bit order
  logic [4:0] ph_v;
  logic [7:0] ln_v;
  logic [3:0] mx_v;
  logic       wr_ln;
  logic       wr_mx;
  assign ph_v = {left_phones_short_release_o, right_phones_short_release_o,
                 right_phones_output_stage_on_o, right_phones_middle_stage_on_o,
                 right_phones_input_stage_on_o};
  assign ln_v = {left_line_short_release_o, left_line_output_stage_on_o,
                 left_line_middle_stage_on_o, left_line_input_stage_on_o,
                 right_line_short_release_o, right_line_output_stage_on_o,
                 right_line_middle_stage_on_o, right_line_input_stage_on_o};
  assign mx_v = {left_phones_bypass_select_o, right_phones_bypass_select_o,
                 left_line_bypass_select_o, right_line_bypass_select_o};
  // frozen strobes do not count, so the enable is part of every access
  assign wr_ln = clk_en_i && reg_wr_i && reg_addr_i == ADDR_LINE;
  assign wr_mx = clk_en_i && reg_wr_i && reg_addr_i == ADDR_MUX;

  // ==========================================================================
  // properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_acc(w, logic [7:0] a);
    clk_en_i && w && reg_addr_i == a;
  endsequence

  a_line_write:
    assert property (s_acc(reg_wr_i, ADDR_LINE) |=> ln_v == $past(reg_wdata_i))
      else $error("line enables do not follow the written byte");
  a_phones_write:
    assert property (s_acc(reg_wr_i, ADDR_PHONES) |=>
      ph_v == {$past(reg_wdata_i[7]), $past(reg_wdata_i[3:0])})
      else $error("phones enables do not follow the written byte");
  a_mux_write:
    assert property (s_acc(reg_wr_i, ADDR_MUX) |=> mx_v == $past(reg_wdata_i[3:0]))
      else $error("mux selects do not follow the written nibble");
  a_line_hold:
    assert property (!wr_ln |=> $stable(ln_v))
      else $error("line enables moved without a write");
  a_mux_hold:
    assert property (!wr_mx |=> $stable(mx_v))
      else $error("mux selects moved without a write");
  a_rdata_idle:
    assert property (clk_en_i && !reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data not zero outside the read cycle");
  a_read_line:
    assert property (s_acc(reg_rd_i, ADDR_LINE) |=> reg_rdata_o == ln_v)
      else $error("line register read mismatch");
  a_read_mux:
    assert property (s_acc(reg_rd_i, ADDR_MUX) |=> reg_rdata_o == {4'h0, mx_v})
      else $error("mux register read mismatch");
  a_read_phones:
    assert property (s_acc(reg_rd_i, ADDR_PHONES) |=>
      {reg_rdata_o[7], reg_rdata_o[3:0]} == ph_v)
      else $error("phones register read mismatch");
  a_reset_outputs_zero:
    assert property ($fell(sys_rst_i) |-> ln_v == 8'h00 && ph_v == 5'h00 && mx_v == 4'h0
      && reg_rdata_o == 8'h00)
      else $error("outputs not cleared by reset");
endmodule

bind osem_regs osem_regs_monitor osem_regs_monitor_inst (.*);

// *** test_output_stage_enable_mux_regs.sv ***
// self-checking bench for the output stage enable and mux register bank
`timescale 1ns/1ps
module test_output_stage_enable_mux_regs;
  import osem_pkg::*;
  // ==========================================================================
  // ports, model and counters
  logic        sys_clk_i   = 1'b0;
  logic        sys_rst_i   = 1'b1;
  logic        clk_en_i    = 1'b1;
  logic [7:0]  reg_addr_i  = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic        right_phones_input_stage_on_o, right_phones_middle_stage_on_o;
  logic        right_phones_output_stage_on_o, right_phones_short_release_o;
  logic        left_phones_short_release_o, left_line_input_stage_on_o;
  logic        left_line_middle_stage_on_o, left_line_output_stage_on_o;
  logic        left_line_short_release_o, right_line_input_stage_on_o;
  logic        right_line_middle_stage_on_o, right_line_output_stage_on_o;
  logic        right_line_short_release_o, left_phones_bypass_select_o;
  logic        right_phones_bypass_select_o, left_line_bypass_select_o;
  logic        right_line_bypass_select_o;
  logic [16:0] got_v;
  logic [31:0] r;
  logic [7:0]  a;
  logic [7:0]  regs [3] = '{ADDR_MUX, ADDR_PHONES, ADDR_LINE};
  int          fails   = 0;
  int          checked = 0;
  int          seed    = 26018;
  int          cycles  = 0;
  int          ph      = 0;
  int          ln      = 0;
  int          mx      = 0;

  always #50 sys_clk_i = ~sys_clk_i;
  osem_regs osem_regs_inst (.*);
  // all control outputs in register bit order: phones, line, mux
  assign got_v = {left_phones_short_release_o, right_phones_short_release_o,
    right_phones_output_stage_on_o, right_phones_middle_stage_on_o,
    right_phones_input_stage_on_o, left_line_short_release_o, left_line_output_stage_on_o,
    left_line_middle_stage_on_o, left_line_input_stage_on_o, right_line_short_release_o,
    right_line_output_stage_on_o, right_line_middle_stage_on_o, right_line_input_stage_on_o,
    left_phones_bypass_select_o, right_phones_bypass_select_o, left_line_bypass_select_o,
    right_line_bypass_select_o};

  // ==========================================================================
  // model, bus tasks and comparisons
  function automatic logic [16:0] ev();
    return {ph[7], ph[3:0], ln[7:0], mx[3:0]};
  endfunction
  function automatic logic [7:0] rx(input logic [7:0] ad);
    case (ad)
      ADDR_MUX:    return 8'(mx);
      ADDR_PHONES: return 8'(ph);
      ADDR_LINE:   return 8'(ln);
      default:     return 8'h00;
    endcase
  endfunction
  task automatic chk_out(input logic [16:0] exp);
    checked++;
    if (got_v !== exp) begin
      fails++;
      $display("[ERR] control outputs expected %h seen %h", exp, got_v);
    end
  endtask
  task automatic chk_rd(input logic [7:0] exp);
    checked++;
    if (reg_rdata_o !== exp) begin
      fails++;
      $display("[ERR] read data expected %h seen %h", exp, reg_rdata_o);
    end
  endtask
  // a write with the enable low must leave the model untouched
  task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic en);
    clk_en_i <= en;
    reg_wr_i <= 1'b1;
    reg_rd_i <= 1'b0;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    #1;
    if (en) begin
      case (ad)
        ADDR_MUX:    mx = d[3:0];
        ADDR_PHONES: ph = d;
        ADDR_LINE:   ln = d;
        default:     ;
      endcase
    end
  endtask
  task automatic rd(input logic [7:0] ad);
    clk_en_i <= 1'b1;
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic idle(input int n);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    clk_en_i <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wrap_up();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // a hang is cut after well over the expected run length
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      wrap_up();
    end
  end

  // ==========================================================================
  // scenarios
  initial begin
    repeat (6) @(posedge sys_clk_i);
    #1;
    sys_rst_i <= 1'b0;
    chk_out(17'h0);
    for (int i = 0; i < 3; i++) begin
      rd(regs[i]);
      chk_rd(8'h00);
    end
    // walking one through each register, every write read straight back
    for (int i = 0; i < 3; i++) begin
      for (int b = 0; b < 8; b++) begin
        wr(regs[i], 8'h01 << b, 1'b1);
        chk_out(ev());
        rd(regs[i]);
        chk_rd(rx(regs[i]));
      end
    end
    idle(1);
    chk_rd(8'h00);
    // back-to-back random traffic, unmapped places and frozen strobes included
    for (int i = 0; i < 80; i++) begin
      r = $random(seed);
      a = {1'b1, r[8:2]};
      if (r[1:0] != 2'd3) begin
        a = regs[r[1:0]];
      end
      if (r[9]) begin
        wr(a, r[23:16], r[11:10] != 2'b00);
        chk_out(ev());
      end else begin
        rd(a);
        chk_rd(rx(a));
      end
    end
    // ordered power-up of all sequenced channels after clearing the flags
    wr(ADDR_LINE, 8'h00, 1'b1);
    wr(ADDR_PHONES, 8'h00, 1'b1);
    wr(ADDR_STAT_A, 8'hFF, 1'b1);
    wr(ADDR_STAT_B, 8'hFF, 1'b1);
    wr(ADDR_LINE, 8'h11, 1'b1);
    wr(ADDR_PHONES, 8'h01, 1'b1);
    idle(int'(SETTLE_CYC));
    wr(ADDR_LINE, 8'h33, 1'b1);
    wr(ADDR_PHONES, 8'h03, 1'b1);
    wr(ADDR_LINE, 8'h77, 1'b1);
    wr(ADDR_PHONES, 8'h07, 1'b1);
    wr(ADDR_LINE, 8'hFF, 1'b1);
    wr(ADDR_PHONES, 8'h8F, 1'b1);
    chk_out(ev());
    rd(ADDR_STAT_A);
    chk_rd(8'h11);
    rd(ADDR_STAT_B);
    chk_rd(8'h01);
    // out of order steps are flagged, an unmapped read marks status B, write one clears
    wr(ADDR_LINE, 8'h00, 1'b1);
    wr(ADDR_PHONES, 8'h00, 1'b1);
    wr(ADDR_LINE, 8'h22, 1'b1);
    wr(ADDR_PHONES, 8'h08, 1'b1);
    rd(8'h80);
    chk_rd(8'h00);
    chk_out(ev());
    rd(ADDR_STAT_A);
    chk_rd(8'h28);
    rd(ADDR_STAT_B);
    chk_rd(8'h82);
    wr(ADDR_STAT_A, 8'hFF, 1'b1);
    wr(ADDR_STAT_B, 8'hFF, 1'b1);
    rd(ADDR_STAT_A);
    chk_rd(8'h00);
    rd(ADDR_STAT_B);
    chk_rd(8'h00);
    // reset in mid-run returns every path to the converter and all stages off
    #20;
    sys_rst_i <= 1'b1;
    #10;
    ph = 0;
    ln = 0;
    mx = 0;
    chk_out(ev());
    idle(2);
    sys_rst_i <= 1'b0;
    rd(ADDR_MUX);
    chk_rd(8'h00);
    wrap_up();
  end
endmodule
